// ---- design/dtc_channel.sv ----
// one timer channel: counter, compare reload, capture and pwm
`timescale 1ns/100ps
`default_nettype none
module dtc_channel #(
    parameter int CNT_W = 8,
    parameter bit HAS_PWM = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic tick,
    input wire logic clr,
    input wire dtc_pkg::dtc_mode_type mode,
    input wire logic cap_rise,
    input wire logic cap_fall,
    input wire logic [CNT_W-1:0] compare,
    // results
    output logic [CNT_W-1:0] count_q,
    output logic [CNT_W-1:0] capture_q,
    output logic match_evt,
    output logic overflow_evt,
    output logic pwm_q
);
    import dtc_pkg::*;

    logic at_max;
    logic at_cmp;
    logic interval;
    logic pwm;
    logic cap_evt;
    logic match_hit;

    assign at_max = (count_q == {CNT_W{1'b1}});
    assign at_cmp = (count_q == compare);
    assign interval = (mode == DTC_MODE_INTERVAL);
    assign pwm = HAS_PWM && (mode == DTC_MODE_CODE3);
    // code 3 means both edges only on a channel without pwm
    assign cap_evt = ((mode == DTC_MODE_CAP_RISE) && cap_rise)
        || ((mode == DTC_MODE_CAP_FALL) && cap_fall)
        || (!HAS_PWM && (mode == DTC_MODE_CODE3) && (cap_rise || cap_fall));
    assign match_hit = tick && at_cmp && (interval || pwm) && !clr;
    assign overflow_evt = tick && at_max && !clr && !(interval && at_cmp);
    assign match_evt = match_hit || cap_evt;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (clr) begin
            count_q <= '0;
        end else if (tick) begin
            if (interval && at_cmp) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            capture_q <= '0;
        end else if (cap_evt) begin
            capture_q <= count_q;
        end
    end

    // output high from wrap until match
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_q <= 1'b0;
        end else if (!pwm) begin
            pwm_q <= 1'b0;
        end else if (overflow_evt) begin
            pwm_q <= 1'b1;
        end else if (match_hit) begin
            pwm_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_interval_reload: assert property (
        interval && tick && at_cmp && !clr |=> count_q == '0
    ) else $error("interval match did not reload counter");
    a_count_step: assert property (
        tick && !clr && !interval |=> count_q == $past(count_q) + 1'b1
    ) else $error("counter did not advance on tick");
    a_capture_copy: assert property (
        cap_evt |=> capture_q == $past(count_q)
    ) else $error("capture did not hold counter value");

endmodule
`default_nettype wire

// ---- design/dtc_pkg.sv ----
// package with register map, field layout and types of the dual timer control block
package dtc_pkg;

    // register offsets in the register file
    localparam logic [7:0] DTC_T0_CTRL_OFFSET = 8'hD2;
    localparam logic [7:0] DTC_T1_CTRL_OFFSET = 8'hFA;
    localparam logic [7:0] DTC_CTRL_RESET = 8'h00;

    // field positions inside a control register
    localparam int DTC_CLKSEL_LSB = 6;
    localparam int DTC_MODE_LSB = 4;
    localparam int DTC_CLEAR_BIT = 3;
    localparam int DTC_OVERFLOW_EN_BIT = 2;
    localparam int DTC_MATCH_EN_BIT = 1;
    localparam int DTC_MATCH_PEND_BIT = 0;

    // prescaler divisors, counted in oscillator cycles
    localparam int DTC_PRESC_W = 12;
    localparam int DTC_T0_DIV_SLOW = 4096;
    localparam int DTC_T0_DIV_MID = 256;
    localparam int DTC_T0_DIV_FAST = 8;
    localparam int DTC_T1_DIV_FAST = 4;
    localparam int DTC_T1_DIV_MID = 8;
    localparam int DTC_T1_DIV_SLOW = 16;

    // counter width is not fixed by the control registers
    localparam int DTC_CNT_W = 8;

    typedef enum logic [1:0] {
        DTC_MODE_INTERVAL = 2'b00,
        DTC_MODE_CAP_RISE = 2'b01,
        DTC_MODE_CAP_FALL = 2'b10,
        DTC_MODE_CODE3 = 2'b11
    } dtc_mode_type;

    typedef struct packed {
        logic [1:0] clk_sel;
        dtc_mode_type mode;
        logic clear;
        logic overflow_en;
        logic match_en;
        logic match_pend;
    } dtc_ctrl_type;

endpackage

// ---- design/dtc_top.sv ----
// top of the dual timer control block: control registers, clock select, pending flags
`timescale 1ns/100ps
`default_nettype none
module dtc_top #(
    parameter int CNT_W = dtc_pkg::DTC_CNT_W
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // register file port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // pins and external sources
    input wire logic TIMER_ZERO_EXTERNAL_CLOCK_PIN,
    input wire logic COUNTER_A_TOGGLE_FLOP,
    input wire logic T0_CAPTURE_PIN,
    input wire logic T1_CAPTURE_PIN,
    // compare values and counter results
    input wire logic [CNT_W-1:0] T0_COMPARE,
    input wire logic [CNT_W-1:0] T1_COMPARE,
    output logic [CNT_W-1:0] TIMER_ZERO_COUNTER,
    output logic [CNT_W-1:0] TIMER_ONE_COUNTER,
    output logic [CNT_W-1:0] T0_CAPTURE_DATA,
    output logic [CNT_W-1:0] T1_CAPTURE_DATA,
    output logic T0_PWM_OUT,
    // interrupt requests and overflow service
    output logic INTERRUPT_LEVEL_ZERO,
    output logic INTERRUPT_LEVEL_ONE,
    output logic T0_OVERFLOW_IRQ,
    output logic T1_OVERFLOW_IRQ,
    input wire logic T0_OVERFLOW_ACK,
    input wire logic T1_OVERFLOW_ACK
);
    import dtc_pkg::*;

    localparam int NSYNC = 4;
    localparam logic [DTC_PRESC_W-1:0] T0_MASK_SLOW = DTC_PRESC_W'(DTC_T0_DIV_SLOW - 1);
    localparam logic [DTC_PRESC_W-1:0] T0_MASK_MID = DTC_PRESC_W'(DTC_T0_DIV_MID - 1);
    localparam logic [DTC_PRESC_W-1:0] T0_MASK_FAST = DTC_PRESC_W'(DTC_T0_DIV_FAST - 1);
    localparam logic [DTC_PRESC_W-1:0] T1_MASK_FAST = DTC_PRESC_W'(DTC_T1_DIV_FAST - 1);
    localparam logic [DTC_PRESC_W-1:0] T1_MASK_MID = DTC_PRESC_W'(DTC_T1_DIV_MID - 1);
    localparam logic [DTC_PRESC_W-1:0] T1_MASK_SLOW = DTC_PRESC_W'(DTC_T1_DIV_SLOW - 1);

    // a divided tick fires when all prescaler bits under the mask are one
    function automatic logic presc_tick(input logic [DTC_PRESC_W-1:0] p, input logic [DTC_PRESC_W-1:0] m);
        presc_tick = ((p & m) == m);
    endfunction

    // read view: clear bit is a write-only command and reads zero
    function automatic logic [7:0] ctrl_view(input dtc_ctrl_type c, input logic pend);
        dtc_ctrl_type v;
        v = c;
        v.clear = 1'b0;
        v.match_pend = pend;
        ctrl_view = v;
    endfunction

    dtc_ctrl_type t0_ctrl_q;
    dtc_ctrl_type t1_ctrl_q;
    logic t0_match_pend_q;
    logic t1_match_pend_q;
    logic t0_ovf_pend_q;
    logic t1_ovf_pend_q;
    logic [DTC_PRESC_W-1:0] presc_q;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] prev_q;
    logic [NSYNC-1:0] rise;
    logic [NSYNC-1:0] fall;
    logic [7:0] rdata_q;
    logic t0_wr;
    logic t1_wr;
    logic t0_clr;
    logic t1_clr;
    logic t0_tick;
    logic t1_tick;
    logic t0_match_evt;
    logic t1_match_evt;
    logic t0_ovf_evt;
    logic t1_ovf_evt;

    assign t0_wr = REG_WR && (REG_ADDR == DTC_T0_CTRL_OFFSET);
    assign t1_wr = REG_WR && (REG_ADDR == DTC_T1_CTRL_OFFSET);
    assign t0_clr = t0_wr && REG_WDATA[DTC_CLEAR_BIT];
    assign t1_clr = t1_wr && REG_WDATA[DTC_CLEAR_BIT];

    // pins arrive from outside the clock domain; sync1 feeds sync2 only
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= {T1_CAPTURE_PIN, T0_CAPTURE_PIN, COUNTER_A_TOGGLE_FLOP, TIMER_ZERO_EXTERNAL_CLOCK_PIN};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_edge
            assign rise[gi] = sync2_q[gi] && !prev_q[gi];
            assign fall[gi] = !sync2_q[gi] && prev_q[gi];
        end
    endgenerate

    // free-running prescaler shared by both timers
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    always_comb begin
        unique case (t0_ctrl_q.clk_sel)
            2'b00: t0_tick = presc_tick(presc_q, T0_MASK_SLOW);
            2'b01: t0_tick = presc_tick(presc_q, T0_MASK_MID);
            2'b10: t0_tick = presc_tick(presc_q, T0_MASK_FAST);
            2'b11: t0_tick = rise[0];
        endcase
    end

    always_comb begin
        unique case (t1_ctrl_q.clk_sel)
            2'b00: t1_tick = presc_tick(presc_q, T1_MASK_FAST);
            2'b01: t1_tick = presc_tick(presc_q, T1_MASK_MID);
            2'b10: t1_tick = presc_tick(presc_q, T1_MASK_SLOW);
            2'b11: t1_tick = rise[1];
        endcase
    end

    // control fields; the clear bit is never stored
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            t0_ctrl_q <= DTC_CTRL_RESET;
        end else if (t0_wr) begin
            t0_ctrl_q <= {REG_WDATA[7:4], 1'b0, REG_WDATA[DTC_OVERFLOW_EN_BIT:DTC_MATCH_EN_BIT], 1'b0};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            t1_ctrl_q <= DTC_CTRL_RESET;
        end else if (t1_wr) begin
            t1_ctrl_q <= {REG_WDATA[7:4], 1'b0, REG_WDATA[DTC_OVERFLOW_EN_BIT:DTC_MATCH_EN_BIT], 1'b0};
        end
    end

    // match pending: a new event wins over a software clear in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            t0_match_pend_q <= 1'b0;
        end else if (t0_match_evt) begin
            t0_match_pend_q <= 1'b1;
        end else if (t0_wr && !REG_WDATA[DTC_MATCH_PEND_BIT]) begin
            t0_match_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            t1_match_pend_q <= 1'b0;
        end else if (t1_match_evt) begin
            t1_match_pend_q <= 1'b1;
        end else if (t1_wr && !REG_WDATA[DTC_MATCH_PEND_BIT]) begin
            t1_match_pend_q <= 1'b0;
        end
    end

    // overflow pending drops when the interrupt logic services it
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            t0_ovf_pend_q <= 1'b0;
        end else if (t0_ovf_evt) begin
            t0_ovf_pend_q <= 1'b1;
        end else if (T0_OVERFLOW_ACK) begin
            t0_ovf_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            t1_ovf_pend_q <= 1'b0;
        end else if (t1_ovf_evt) begin
            t1_ovf_pend_q <= 1'b1;
        end else if (T1_OVERFLOW_ACK) begin
            t1_ovf_pend_q <= 1'b0;
        end
    end

    // read data registered, one cycle after the address
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rdata_q <= '0;
        end else if (REG_ADDR == DTC_T0_CTRL_OFFSET) begin
            rdata_q <= ctrl_view(t0_ctrl_q, t0_match_pend_q);
        end else if (REG_ADDR == DTC_T1_CTRL_OFFSET) begin
            rdata_q <= ctrl_view(t1_ctrl_q, t1_match_pend_q);
        end else begin
            rdata_q <= '0;
        end
    end

    dtc_channel #(
        .CNT_W(CNT_W),
        .HAS_PWM(1'b1)
    ) u_timer_zero (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(t0_tick),
        .clr(t0_clr),
        .mode(t0_ctrl_q.mode),
        .cap_rise(rise[2]),
        .cap_fall(fall[2]),
        .compare(T0_COMPARE),
        .count_q(TIMER_ZERO_COUNTER),
        .capture_q(T0_CAPTURE_DATA),
        .match_evt(t0_match_evt),
        .overflow_evt(t0_ovf_evt),
        .pwm_q(T0_PWM_OUT)
    );

    // the second channel has no pwm; code 3 captures on both edges
    dtc_channel #(
        .CNT_W(CNT_W),
        .HAS_PWM(1'b0)
    ) u_timer_one (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(t1_tick),
        .clr(t1_clr),
        .mode(t1_ctrl_q.mode),
        .cap_rise(rise[3]),
        .cap_fall(fall[3]),
        .compare(T1_COMPARE),
        .count_q(TIMER_ONE_COUNTER),
        .capture_q(T1_CAPTURE_DATA),
        .match_evt(t1_match_evt),
        .overflow_evt(t1_ovf_evt),
        .pwm_q()
    );

    assign REG_RDATA = rdata_q;
    assign INTERRUPT_LEVEL_ZERO = t0_ctrl_q.match_en && t0_match_pend_q;
    assign INTERRUPT_LEVEL_ONE = t1_ctrl_q.match_en && t1_match_pend_q;
    assign T0_OVERFLOW_IRQ = t0_ctrl_q.overflow_en && t0_ovf_pend_q;
    assign T1_OVERFLOW_IRQ = t1_ctrl_q.overflow_en && t1_ovf_pend_q;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_reset_zero: assert property (disable iff (1'b0)
        !RST_N |=> (t0_ctrl_q == DTC_CTRL_RESET) && (t1_ctrl_q == DTC_CTRL_RESET) && !INTERRUPT_LEVEL_ZERO
    ) else $error("control not zero after reset");
    a_t0_slow_tick: assert property (
        t0_ctrl_q.clk_sel == 2'b00 && t0_tick |-> presc_q == T0_MASK_SLOW
    ) else $error("timer zero slow tick off period");
    a_t1_fast_tick: assert property (
        t1_ctrl_q.clk_sel == 2'b00 && t1_tick |=> !t1_tick[*3]
    ) else $error("timer one fast tick too frequent");
    a_t0_clear_cmd: assert property (
        t0_clr |=> TIMER_ZERO_COUNTER == '0
    ) else $error("timer zero clear command ignored");
    a_t1_clear_cmd: assert property (
        t1_clr |=> TIMER_ONE_COUNTER == '0
    ) else $error("timer one clear command ignored");
    a_t0_pend_set: assert property (
        t0_match_evt |=> t0_match_pend_q && (t0_ctrl_q.match_en == INTERRUPT_LEVEL_ZERO)
    ) else $error("timer zero match not pending");
    a_t0_pend_clear: assert property (
        t0_wr && !REG_WDATA[DTC_MATCH_PEND_BIT] && !t0_match_evt |=> !t0_match_pend_q
    ) else $error("timer zero pending not cleared by write");
    a_t1_pend_keep: assert property (
        t1_match_pend_q && t1_wr && REG_WDATA[DTC_MATCH_PEND_BIT] |=> t1_match_pend_q
    ) else $error("timer one pending lost on write of one");
    a_t0_ovf_service: assert property (
        T0_OVERFLOW_ACK && !t0_ovf_evt |=> !T0_OVERFLOW_IRQ
    ) else $error("timer zero overflow not cleared on service");
    a_t1_ovf_gate: assert property (
        t1_ovf_evt && t1_ctrl_q.overflow_en && !t1_wr |=> T1_OVERFLOW_IRQ
    ) else $error("timer one overflow request not raised");
    a_pwm_requests: assert property (
        t0_ctrl_q.mode == DTC_MODE_CODE3 && t0_ovf_evt && !T0_OVERFLOW_ACK |=> t0_ovf_pend_q
    ) else $error("pwm overflow not pending");
    a_pwm_out_wrap: assert property (
        t0_ctrl_q.mode == DTC_MODE_CODE3 && t0_ovf_evt && !t0_wr |=> T0_PWM_OUT
    ) else $error("pwm output not set on wrap");
    a_t0_ovf_gate: assert property (
        t0_ovf_evt && t0_ctrl_q.overflow_en && !t0_wr |=> T0_OVERFLOW_IRQ
    ) else $error("timer zero overflow request not raised");
    a_t1_ovf_service: assert property (
        T1_OVERFLOW_ACK && !t1_ovf_evt |=> !T1_OVERFLOW_IRQ
    ) else $error("timer one overflow not cleared on service");
    a_t1_pend_set: assert property (
        t1_match_evt |=> t1_match_pend_q
    ) else $error("timer one match not pending");
    a_t1_pend_clear: assert property (
        t1_wr && !REG_WDATA[DTC_MATCH_PEND_BIT] && !t1_match_evt |=> !t1_match_pend_q
    ) else $error("timer one pending not cleared by write");
    a_t0_pend_keep: assert property (
        t0_match_pend_q && t0_wr && REG_WDATA[DTC_MATCH_PEND_BIT] |=> t0_match_pend_q
    ) else $error("timer zero pending lost on write of one");
    a_t0_fall_capture: assert property (
        t0_ctrl_q.mode == DTC_MODE_CAP_FALL && fall[2] |=> t0_match_pend_q
    ) else $error("timer zero falling capture not pending");
    a_t1_both_capture: assert property (
        t1_ctrl_q.mode == DTC_MODE_CODE3 && (rise[3] || fall[3]) |=> t1_match_pend_q
    ) else $error("timer one both-edge capture not pending");

    c_t0_capture: cover property (t0_ctrl_q.mode == DTC_MODE_CAP_RISE && t0_match_evt);
    c_t0_pwm_wrap: cover property (t0_ctrl_q.mode == DTC_MODE_CODE3 && t0_ovf_evt ##[1:600] t0_match_evt);
    c_t1_both_edges: cover property (t1_ctrl_q.mode == DTC_MODE_CODE3 && fall[3] && t1_match_evt);
    c_t1_interval: cover property (t1_ctrl_q.mode == DTC_MODE_INTERVAL && t1_match_evt);

endmodule
`default_nettype wire

// ---- dv/dtc_pin_model.sv ----
// far-side model: timer clock pins and capture pins
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
    // clock
    input wire logic clk,
    // pins
    output logic ext_clk_pin,
    output logic toggle_flop,
    output logic cap0_pin,
    output logic cap1_pin
);
    initial begin
        ext_clk_pin = 1'b0;
        toggle_flop = 1'b0;
        cap0_pin = 1'b0;
        cap1_pin = 1'b0;
    end
    // levels are held at least two clocks, shorter pulses may be lost in the synchronisers
    task automatic tick(input int which, input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (which == 0) ext_clk_pin <= 1'b1;
            else toggle_flop <= 1'b1;
            repeat (hold) @(posedge clk);
            if (which == 0) ext_clk_pin <= 1'b0;
            else toggle_flop <= 1'b0;
            repeat (hold) @(posedge clk);
        end
    endtask
    task automatic cap(input int which, input logic lvl, input int hold);
        @(posedge clk);
        if (which == 0) cap0_pin <= lvl;
        else cap1_pin <= lvl;
        repeat (hold) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// testbench of the dual timer control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h expected %h", $time, (g), (e)); end end
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n, reg_wr, pwm, interrupt_level_zero, interrupt_level_one, ovf0, ovf1, ack0, ack1, ext_clk, tff, cap0, cap1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cmp0, cmp1, cnt0, cnt1, capd0, capd1;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 32'h1aa1;
    int mc[2];
    int dv[2][3] = '{'{4096, 256, 8}, '{4, 8, 16}};
    int c, n, mx;
    logic [7:0] ad, base, r;
    always #5 sys_clk = ~sys_clk;
    dtc_top u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .TIMER_ZERO_EXTERNAL_CLOCK_PIN(ext_clk),
        .COUNTER_A_TOGGLE_FLOP(tff), .T0_CAPTURE_PIN(cap0), .T1_CAPTURE_PIN(cap1),
        .T0_COMPARE(cmp0), .T1_COMPARE(cmp1), .TIMER_ZERO_COUNTER(cnt0), .TIMER_ONE_COUNTER(cnt1),
        .T0_CAPTURE_DATA(capd0), .T1_CAPTURE_DATA(capd1), .T0_PWM_OUT(pwm),
        .INTERRUPT_LEVEL_ZERO(interrupt_level_zero), .INTERRUPT_LEVEL_ONE(interrupt_level_one), .T0_OVERFLOW_IRQ(ovf0),
        .T1_OVERFLOW_IRQ(ovf1), .T0_OVERFLOW_ACK(ack0), .T1_OVERFLOW_ACK(ack1));
    dtc_pin_model u_pins (.clk(sys_clk), .ext_clk_pin(ext_clk), .toggle_flop(tff), .cap0_pin(cap0),
        .cap1_pin(cap1));
    function automatic logic [7:0] cnt(input int t);
        return (t == 0) ? cnt0 : cnt1;
    endfunction
    function automatic logic mirq(input int t);
        return (t == 0) ? interrupt_level_zero : interrupt_level_one;
    endfunction
    function automatic logic movf(input int t);
        return (t == 0) ? ovf0 : ovf1;
    endfunction
    function automatic int rnd(input int lo, input int hi);
        return lo + ($unsigned($random(seed)) % (hi - lo + 1));
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        cyc(1);
        `CHK(reg_rdata, e);
    endtask
    task automatic ack(input int t);
        @(posedge sys_clk);
        if (t == 0) ack0 <= 1'b1;
        else ack1 <= 1'b1;
        @(posedge sys_clk);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
        cyc(1);
    endtask
    // pin edges pass two synchroniser flops and an edge detect before they count
    task automatic pulses(input int w, input int k);
        u_pins.tick(w, k, rnd(2, 4));
        mc[w] = (mc[w] + k) % 256;
        cyc(6);
    endtask
    task automatic capt(input int w, input logic lvl);
        u_pins.cap(w, lvl, rnd(2, 4));
        cyc(6);
    endtask
    // the shared prescaler free-runs, so only the spacing of counter steps is predictable
    task automatic period(input int t, input int e);
        logic [7:0] c0;
        int k;
        // start past the write edge so the first sample is settled
        cyc(1);
        for (int p = 0; p < 2; p++) begin
            c0 = cnt(t);
            k = 0;
            while (cnt(t) === c0 && k < 9000) begin
                cyc(1);
                k++;
            end
        end
        `CHK(k, e);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cmp0 = 8'hFF;
        cmp1 = 8'hFF;
        ack0 = 1'b0;
        ack1 = 1'b0;
        mc = '{0, 0};
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(8'hD2, 8'h00);
        rd_chk(8'hFA, 8'h00);
        r = 8'($random(seed));
        wr(8'hD2, r);
        rd_chk(8'hD2, r & 8'hF6);
        wr(8'h55, 8'hFF);
        rd_chk(8'h55, 8'h00);
        // clock selects, each timer in interval mode with the match at the top of the count
        for (int t = 0; t < 2; t++) begin
            for (int s = 0; s < 3; s++) begin
                wr(t ? 8'hFA : 8'hD2, 8'(s << 6));
                period(t, dv[t][s]);
            end
        end
        // interval match, pending flag and enable gating
        for (int t = 0; t < 2; t++) begin
            ad = t ? 8'hFA : 8'hD2;
            base = t ? 8'h00 : 8'h80;
            c = rnd(3, 30);
            if (t == 0) cmp0 <= 8'(c);
            else cmp1 <= 8'(c);
            wr(ad, base | 8'h0A);
            cyc(1);
            mx = 0;
            n = 0;
            while (mirq(t) !== 1'b1 && n < 400) begin
                if (int'(cnt(t)) > mx) mx = int'(cnt(t));
                cyc(1);
                n++;
            end
            `CHK(mx, c);
            `CHK(cnt(t), 8'h00);
            rd_chk(ad, base | 8'h03);
            wr(ad, base | 8'h03);
            rd_chk(ad, base | 8'h03);
            wr(ad, base | 8'h02);
            rd_chk(ad, base | 8'h02);
            `CHK(mirq(t), 1'b0);
            wr(ad, base);
            cyc((c + 2) * dv[t][2 - 2 * t]);
            rd_chk(ad, base | 8'h01);
            `CHK(mirq(t), 1'b0);
        end
        // overflow in capture mode, enable gating and service clear
        for (int t = 0; t < 2; t++) begin
            ad = t ? 8'hFA : 8'hD2;
            base = t ? 8'h10 : 8'h90;
            wr(ad, base | 8'h0C);
            n = 0;
            while (movf(t) !== 1'b1 && n < 2200) begin
                cyc(1);
                n++;
            end
            `CHK(cnt(t), 8'h00);
            ack(t);
            `CHK(movf(t), 1'b0);
            wr(ad, base);
            cyc(2100);
            `CHK(movf(t), 1'b0);
            wr(ad, base | 8'h04);
            cyc(1);
            `CHK(movf(t), 1'b1);
            ack(t);
        end
        // capture on pin edges, counters clocked from the pins
        wr(8'hD2, 8'hDA);
        mc[0] = 0;
        pulses(0, rnd(1, 20));
        capt(0, 1'b1);
        `CHK(capd0, 8'(mc[0]));
        `CHK(interrupt_level_zero, 1'b1);
        wr(8'hD2, 8'hE2);
        pulses(0, rnd(1, 20));
        capt(0, 1'b0);
        `CHK(capd0, 8'(mc[0]));
        wr(8'hD2, 8'hE2);
        r = capd0;
        pulses(0, 3);
        capt(0, 1'b1);
        `CHK(capd0, r);
        `CHK(interrupt_level_zero, 1'b0);
        wr(8'hFA, 8'hFA);
        mc[1] = 0;
        pulses(1, rnd(1, 20));
        capt(1, 1'b1);
        `CHK(capd1, 8'(mc[1]));
        wr(8'hFA, 8'hF2);
        pulses(1, rnd(1, 20));
        capt(1, 1'b0);
        `CHK(capd1, 8'(mc[1]));
        `CHK(interrupt_level_one, 1'b1);
        wr(8'hFA, 8'hE2);
        r = capd1;
        pulses(1, 2);
        capt(1, 1'b1);
        `CHK(capd1, r);
        `CHK(interrupt_level_one, 1'b0);
        // clear command: zero has no effect, one clears
        for (int t = 0; t < 2; t++) begin
            ad = t ? 8'hFA : 8'hD2;
            base = t ? 8'hF2 : 8'hE2;
            wr(ad, base);
            cyc(1);
            `CHK(cnt(t), 8'(mc[t]));
            wr(ad, base | 8'h08);
            cyc(1);
            `CHK(cnt(t), 8'h00);
            rd_chk(ad, base);
        end
        // pwm: match without reload, overflow on wrap
        c = rnd(10, 200);
        cmp0 <= 8'(c);
        wr(8'hD2, 8'hFE);
        ack(0);
        mc[0] = 0;
        pulses(0, c + 1);
        `CHK(cnt0, 8'(c + 1));
        `CHK(ovf0, 1'b0);
        `CHK(interrupt_level_zero, 1'b1);
        `CHK(pwm, 1'b0);
        pulses(0, 255 - c);
        `CHK(cnt0, 8'h00);
        `CHK(ovf0, 1'b1);
        `CHK(pwm, 1'b1);
        ack(0);
        `CHK(ovf0, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
